/* otss_defs.vh */
`ifndef OTSS_DEFS_VH
`define OTSS_DEFS_VH
// Terminal function codes.
`define OTSS_FN_NONE 6'h00
`define OTSS_FN_FREQ_LIMITED 6'h0d
`define OTSS_FN_TORQUE_LIMITED 6'h0e
`define OTSS_FN_READY 6'h0f
`define OTSS_FN_ANALOG_GT 6'h10
`define OTSS_FN_UPPER_REACHED 6'h11
`define OTSS_FN_LOWER_NO_STOP 6'h12
`define OTSS_FN_UNDERVOLT 6'h13
`define OTSS_FN_COMM 6'h14
`define OTSS_FN_ZERO_SPEED2 6'h17
`define OTSS_FN_POWER_ON_TIME 6'h18
`define OTSS_FN_TIMING 6'h1e
`define OTSS_FN_ANALOG_LIMIT 6'h1f
`define OTSS_FN_LOAD_ZERO 6'h20
`define OTSS_FN_REVERSE 6'h21
`define OTSS_FN_HEATSINK_TEMP 6'h23
`define OTSS_FN_LOWER_AT_STOP 6'h25
`define OTSS_FN_ALARM 6'h26
`define OTSS_FN_MOTOR_OVERHEAT 6'h27
`define OTSS_FN_RUN_TIME 6'h28
// Pulse output frequency range in units of 0.01 kHz.
`define OTSS_PULSE_MIN_FREQ 14'h0001
`define OTSS_PULSE_MAX_LIMIT 14'h2710
`define OTSS_PULSE_MAX_DEFAULT 14'h1388
// Terminal output reset value: every terminal low, whatever its polarity.
`define OTSS_POLARITY_RESET 5'h00
`endif

/* otss_selector.v */
// Contract
// - Code 13: ON when set frequency beyond limit and output reached that limit.
// - Code 14: ON when torque limited in speed mode, with stall protection.
// - Code 15: ON when circuits stable, no fault, ready to run.
// - Code 16: ON while first analog input exceeds second.
// - Code 17: ON while running frequency at upper limit.
// - Code 18: ON at lower limit, forced OFF while stopped.
// - Code 37: ON at lower limit, stays ON while stopped.
// - Code 19: ON while in undervoltage.
// - Code 20: level comes from the communication-written value.
// - Code 23: ON when output frequency zero, also ON while stopped.
// - Code 24: ON once power-on time exceeds its threshold.
// - Code 30: ON when timing enabled and run time reaches set time.
// - Code 31: ON when first analog input is above upper or below lower limit.
// - Code 32: ON when load has dropped to zero.
// - Code 33: ON while running in reverse.
// - Code 35: ON when heatsink temperature reaches threshold.
// - Code 38: alarm when fault present while still running.
// - Code 39: ON when motor temperature reaches overheat threshold.
// - Code 40: ON when current run time exceeds threshold.
// - Pulse output 0.01 kHz to a maximum clamped to 0.01..100.00 kHz.
// - Code 0: terminal inactive.
// - Per-terminal polarity, 1 inverts, all default positive.
`timescale 1ns/1ps
`include "otss_defs.vh"

module otss_selector #(
   parameter NUM_TERM = 5,
   parameter AW = 12,
   parameter TW = 16,
   parameter FW = 14
) (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   // Terminal configuration
   input wire [6*NUM_TERM-1:0] term_function,
   input wire [NUM_TERM-1:0] output_polarity_select,
   input wire [NUM_TERM-1:0] comm_level,
   // Thresholds
   input wire timing_function_enable,
   input wire [AW-1:0] analog_in_one_lower_limit,
   input wire [AW-1:0] analog_in_one_upper_limit,
   input wire [TW-1:0] power_on_time_threshold,
   input wire [TW-1:0] run_time_threshold,
   input wire [TW-1:0] timing_set_time,
   input wire [TW-1:0] heatsink_temp_threshold,
   input wire [TW-1:0] motor_overheat_threshold,
   // Pulse output configuration
   input wire [FW-1:0] max_pulse_output_frequency,
   // Status from the control core
   input wire set_freq_beyond_limit,
   input wire out_freq_at_limit,
   input wire speed_mode,
   input wire torque_at_limit,
   input wire circuits_stable,
   input wire fault_present,
   input wire drive_running,
   input wire undervoltage,
   input wire out_freq_zero,
   input wire run_freq_at_upper,
   input wire run_freq_at_lower,
   input wire load_zero,
   input wire reverse_running,
   // Measured values
   input wire [AW-1:0] analog_input_one,
   input wire [AW-1:0] analog_input_two,
   input wire [TW-1:0] accumulated_power_on_time,
   input wire [TW-1:0] current_run_time,
   input wire [TW-1:0] heatsink_temp,
   input wire [TW-1:0] motor_temp,
   // Pulse request
   input wire [FW-1:0] pulse_freq_request,
   // Terminal outputs
   output reg [NUM_TERM-1:0] terminal_out,
   // Pulse outputs
   output reg [FW-1:0] pulse_out_freq,
   output reg [FW-1:0] pulse_max_eff,
   // Protection
   output reg stall_protect
);

   // Next-state values of the registered outputs.
   wire [NUM_TERM-1:0] terminal_nxt;
   reg [FW-1:0] max_nxt;
   reg [FW-1:0] freq_nxt;
   reg stall_nxt;

   // Frequency conditions.
   reg c_freq_lim;
   reg c_upper;
   reg c_lower_ns;
   reg c_lower_st;
   reg c_zero2;
   reg c_rev;

   // Protection and readiness conditions.
   reg c_torque;
   reg c_ready;
   reg c_uv;
   reg c_load;
   reg c_alarm;

   // Analog input conditions.
   reg c_ai_gt;
   reg c_ai_lim;
   reg ai_above_upper;
   reg ai_below_lower;

   // Time and temperature conditions.
   reg c_pon;
   reg c_timing;
   reg c_run;
   reg c_heat;
   reg c_motor;

   // Pulse clamp comparisons.
   reg max_too_low;
   reg max_too_high;
   reg req_too_low;
   reg req_too_high;

   // Conditions derived from the frequency status flags.
   always @* begin
      c_freq_lim = set_freq_beyond_limit & out_freq_at_limit;
      c_upper = run_freq_at_upper;
      c_lower_ns = run_freq_at_lower & drive_running;
      c_lower_st = run_freq_at_lower | ~drive_running;
      c_zero2 = out_freq_zero | ~drive_running;
      c_rev = reverse_running & drive_running;
   end

   // A fault or undervoltage keeps the ready condition low.
   always @* begin
      c_torque = speed_mode & torque_at_limit;
      c_ready = circuits_stable & ~fault_present & ~undervoltage;
      c_uv = undervoltage;
      c_load = load_zero;
      c_alarm = fault_present & drive_running;
   end

   // The limit window on the first analog input is closed at both ends.
   always @* begin
      ai_above_upper = analog_input_one > analog_in_one_upper_limit;
      ai_below_lower = analog_input_one < analog_in_one_lower_limit;
      c_ai_gt = analog_input_one > analog_input_two;
      c_ai_lim = ai_above_upper | ai_below_lower;
   end

   // Power-on and run-time thresholds must be exceeded.
   // The timing set time and the temperature thresholds need only be reached.
   always @* begin
      c_pon = accumulated_power_on_time > power_on_time_threshold;
      c_run = current_run_time > run_time_threshold;
      c_timing = timing_function_enable & (current_run_time >= timing_set_time);
      c_heat = heatsink_temp >= heatsink_temp_threshold;
      c_motor = motor_temp >= motor_overheat_threshold;
   end

   // The stall flag follows the torque-limited condition.
   always @* begin
      stall_nxt = c_torque;
   end

   // One multiplexer per terminal, then its polarity inversion.
   genvar g;
   generate
      for (g = 0; g < NUM_TERM; g = g + 1) begin : g_term
         wire [5:0] code;
         reg lvl;
         assign code = term_function[6*g +: 6];
         always @* begin
            case (code)
               `OTSS_FN_FREQ_LIMITED: begin
                  lvl = c_freq_lim;
               end
               `OTSS_FN_TORQUE_LIMITED: begin
                  lvl = c_torque;
               end
               `OTSS_FN_READY: begin
                  lvl = c_ready;
               end
               `OTSS_FN_ANALOG_GT: begin
                  lvl = c_ai_gt;
               end
               `OTSS_FN_UPPER_REACHED: begin
                  lvl = c_upper;
               end
               `OTSS_FN_LOWER_NO_STOP: begin
                  lvl = c_lower_ns;
               end
               `OTSS_FN_LOWER_AT_STOP: begin
                  lvl = c_lower_st;
               end
               `OTSS_FN_UNDERVOLT: begin
                  lvl = c_uv;
               end
               `OTSS_FN_COMM: begin
                  lvl = comm_level[g];
               end
               `OTSS_FN_ZERO_SPEED2: begin
                  lvl = c_zero2;
               end
               `OTSS_FN_POWER_ON_TIME: begin
                  lvl = c_pon;
               end
               `OTSS_FN_TIMING: begin
                  lvl = c_timing;
               end
               `OTSS_FN_ANALOG_LIMIT: begin
                  lvl = c_ai_lim;
               end
               `OTSS_FN_LOAD_ZERO: begin
                  lvl = c_load;
               end
               `OTSS_FN_REVERSE: begin
                  lvl = c_rev;
               end
               `OTSS_FN_HEATSINK_TEMP: begin
                  lvl = c_heat;
               end
               `OTSS_FN_ALARM: begin
                  lvl = c_alarm;
               end
               `OTSS_FN_MOTOR_OVERHEAT: begin
                  lvl = c_motor;
               end
               `OTSS_FN_RUN_TIME: begin
                  lvl = c_run;
               end
               `OTSS_FN_NONE: begin
                  lvl = 1'b0;
               end
               default: begin
                  lvl = 1'b0;
               end
            endcase
         end
         // Inversion follows selection, so an unused inverted terminal idles high.
         assign terminal_nxt[g] = lvl ^ output_polarity_select[g];
      end
   endgenerate

   // Comparisons of the configured maximum against the legal range.
   always @* begin
      max_too_low = max_pulse_output_frequency < `OTSS_PULSE_MIN_FREQ;
      max_too_high = max_pulse_output_frequency > `OTSS_PULSE_MAX_LIMIT;
   end

   // The maximum is clamped first, so the request is held under the clamped value.
   always @* begin
      if (max_too_low) begin
         max_nxt = `OTSS_PULSE_MIN_FREQ;
      end else if (max_too_high) begin
         max_nxt = `OTSS_PULSE_MAX_LIMIT;
      end else begin
         max_nxt = max_pulse_output_frequency;
      end
   end

   always @* begin
      req_too_low = pulse_freq_request < `OTSS_PULSE_MIN_FREQ;
      req_too_high = pulse_freq_request > max_nxt;
   end

   always @* begin
      if (req_too_low) begin
         freq_nxt = `OTSS_PULSE_MIN_FREQ;
      end else if (req_too_high) begin
         freq_nxt = max_nxt;
      end else begin
         freq_nxt = pulse_freq_request;
      end
   end

   // Terminal levels.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         terminal_out <= `OTSS_POLARITY_RESET;
      end else if (clk_en) begin
         terminal_out <= terminal_nxt;
      end
   end

   // Pulse output frequency.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_out_freq <= `OTSS_PULSE_MIN_FREQ;
      end else if (clk_en) begin
         pulse_out_freq <= freq_nxt;
      end
   end

   // Effective pulse maximum.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_max_eff <= `OTSS_PULSE_MAX_DEFAULT;
      end else if (clk_en) begin
         pulse_max_eff <= max_nxt;
      end
   end

   // Stall protection flag.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stall_protect <= 1'b0;
      end else if (clk_en) begin
         stall_protect <= stall_nxt;
      end
   end

endmodule // otss_selector

/* otss_props.sv */
`timescale 1ns/1ps
module otss_props #(parameter NUM_TERM = 5, parameter FW = 14) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Watched inputs
   input wire clk_en,
   input wire [6*NUM_TERM-1:0] term_function,
   input wire [NUM_TERM-1:0] output_polarity_select,
   input wire [NUM_TERM-1:0] comm_level,
   input wire undervoltage,
   input wire speed_mode,
   input wire torque_at_limit,
   // Watched outputs
   input wire [NUM_TERM-1:0] terminal_out,
   input wire [FW-1:0] pulse_out_freq,
   input wire [FW-1:0] pulse_max_eff,
   input wire stall_protect
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire [5:0] fn0 = term_function[5:0];
   wire go = clk_en && !output_polarity_select[0];
   a_undervolt_term: assert property (go && fn0 == 6'h13 |=> terminal_out[0] == $past(undervoltage))
      else $error("undervoltage terminal wrong");
   a_comm_term: assert property (go && fn0 == 6'h14 |=> terminal_out[0] == $past(comm_level[0]))
      else $error("comm terminal wrong");
   a_none_off: assert property (go && fn0 == 6'h00 |=> !terminal_out[0])
      else $error("unused terminal on");
   a_pol_inverts: assert property (clk_en && fn0 == 6'h00 && output_polarity_select[0] |=> terminal_out[0])
      else $error("inverted terminal off");
   a_reserved_off: assert property (go && fn0 == 6'h15 |=> !terminal_out[0])
      else $error("reserved code terminal on");
   a_stall_torque: assert property (clk_en |=> stall_protect == $past(speed_mode && torque_at_limit))
      else $error("stall flag wrong");
   a_pmax_range: assert property (pulse_max_eff >= 14'h0001 && pulse_max_eff <= 14'h2710)
      else $error("pulse max out of range");
   a_pfreq_range: assert property (pulse_out_freq >= 14'h0001 && pulse_out_freq <= pulse_max_eff)
      else $error("pulse freq out of range");
   a_freeze_hold: assert property (!clk_en |=> $stable(terminal_out) && $stable(pulse_out_freq)
      && $stable(pulse_max_eff) && $stable(stall_protect))
      else $error("outputs changed while clock enable low");
   cover property (fn0 == 6'h13 && undervoltage);
   cover property (stall_protect);
   cover property (pulse_max_eff == 14'h2710);
   cover property (!clk_en && fn0 == 6'h13 && undervoltage);
endmodule // otss_props
bind otss_selector otss_props #(.NUM_TERM(NUM_TERM), .FW(FW)) props_u (
   .clk(clk),
   .sys_rst(sys_rst),
   .clk_en(clk_en),
   .term_function(term_function),
   .output_polarity_select(output_polarity_select),
   .comm_level(comm_level),
   .undervoltage(undervoltage),
   .speed_mode(speed_mode),
   .torque_at_limit(torque_at_limit),
   .terminal_out(terminal_out),
   .pulse_out_freq(pulse_out_freq),
   .pulse_max_eff(pulse_max_eff),
   .stall_protect(stall_protect)
);

/* otss_reader.sv */
`timescale 1ns/1ps
module otss_reader (
   // Clock
   input wire clk,
   // Terminal levels from the drive
   input wire [4:0] terminal_out,
   // Levels as latched by the machinery
   output reg [4:0] seen_r
);
   always @(posedge clk) begin
      seen_r <= terminal_out;
   end
endmodule // otss_reader

/* tb.sv */
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [4:0] pol = 5'h00;
   reg [5:0] fn = 6'h00;
   reg [14:0] st = 15'h0000;
   reg [15:0] v = 16'h0000;
   reg [13:0] pmax = 14'h1388;
   reg [13:0] preq = 14'h0000;
   reg en = 1'b1;
   reg [15:0] thr = 16'h0100;
   wire stall;
   wire [4:0] term;
   wire [4:0] seen;
   wire [13:0] pout;
   wire [13:0] peff;
   integer errors = 0;
   integer tests_run = 0;
   integer cyc = 0;
   otss_selector dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(en), .term_function({5{fn}}),
      .output_polarity_select(pol), .comm_level({5{st[13]}}), .timing_function_enable(st[14]),
      .analog_in_one_lower_limit(12'h080), .analog_in_one_upper_limit(12'h200),
      .power_on_time_threshold(thr), .run_time_threshold(thr),
      .timing_set_time(thr), .heatsink_temp_threshold(thr),
      .motor_overheat_threshold(thr), .max_pulse_output_frequency(pmax),
      .set_freq_beyond_limit(st[12]), .out_freq_at_limit(st[11]), .speed_mode(st[10]),
      .torque_at_limit(st[9]), .circuits_stable(st[8]), .fault_present(st[7]),
      .drive_running(st[6]), .undervoltage(st[5]), .out_freq_zero(st[4]),
      .run_freq_at_upper(st[3]), .run_freq_at_lower(st[2]), .load_zero(st[1]),
      .reverse_running(st[0]), .analog_input_one(v[11:0]), .analog_input_two(12'h100),
      .accumulated_power_on_time(v), .current_run_time(v), .heatsink_temp(v), .motor_temp(v),
      .pulse_freq_request(preq), .terminal_out(term), .pulse_out_freq(pout),
      .pulse_max_eff(peff), .stall_protect(stall));
   otss_reader rd_u (.clk(clk), .terminal_out(term), .seen_r(seen));
   task finish_test;
      begin
         if (errors == 0 && tests_run > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [15:0] s, input [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   // Sets code and status at an edge, then checks what the machinery latched.
   task ap(input [5:0] c, input [14:0] s, input [15:0] x, input e);
      begin
         @(posedge clk);
         fn <= c;
         st <= s;
         v <= x;
         repeat (2) @(posedge clk);
         @(negedge clk) chk({11'h000, seen}, {11'h000, {5{e}} ^ pol});
      end
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         errors = errors + 1;
         finish_test;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      chk({11'h000, term}, 16'h0000);
      chk({2'h0, peff}, 16'h1388);
      sys_rst <= 1'b0;
      ap(6'h0d, 15'h1800, 16'h0000, 1'b1);
      ap(6'h0d, 15'h1000, 16'h0000, 1'b0);
      ap(6'h0e, 15'h0600, 16'h0000, 1'b1);
      chk({15'h0000, stall}, 16'h0001);
      ap(6'h0e, 15'h0200, 16'h0000, 1'b0);
      chk({15'h0000, stall}, 16'h0000);
      ap(6'h0f, 15'h0100, 16'h0000, 1'b1);
      ap(6'h0f, 15'h0180, 16'h0000, 1'b0);
      ap(6'h10, 15'h0000, 16'h0101, 1'b1);
      ap(6'h10, 15'h0000, 16'h0100, 1'b0);
      ap(6'h11, 15'h0008, 16'h0000, 1'b1);
      ap(6'h11, 15'h0000, 16'h0000, 1'b0);
      ap(6'h12, 15'h0044, 16'h0000, 1'b1);
      ap(6'h12, 15'h0004, 16'h0000, 1'b0);
      ap(6'h25, 15'h0004, 16'h0000, 1'b1);
      ap(6'h25, 15'h0040, 16'h0000, 1'b0);
      ap(6'h13, 15'h0020, 16'h0000, 1'b1);
      ap(6'h13, 15'h0000, 16'h0000, 1'b0);
      ap(6'h14, 15'h2000, 16'h0000, 1'b1);
      ap(6'h14, 15'h0000, 16'h0000, 1'b0);
      ap(6'h17, 15'h0050, 16'h0000, 1'b1);
      ap(6'h17, 15'h0040, 16'h0000, 1'b0);
      ap(6'h18, 15'h0000, 16'h0101, 1'b1);
      ap(6'h18, 15'h0000, 16'h0100, 1'b0);
      ap(6'h1e, 15'h4000, 16'h0100, 1'b1);
      ap(6'h1e, 15'h0000, 16'h0100, 1'b0);
      ap(6'h1f, 15'h0000, 16'h0201, 1'b1);
      ap(6'h1f, 15'h0000, 16'h007f, 1'b1);
      ap(6'h1f, 15'h0000, 16'h0100, 1'b0);
      ap(6'h20, 15'h0002, 16'h0000, 1'b1);
      ap(6'h20, 15'h0000, 16'h0000, 1'b0);
      ap(6'h21, 15'h0041, 16'h0000, 1'b1);
      ap(6'h21, 15'h0001, 16'h0000, 1'b0);
      ap(6'h23, 15'h0000, 16'h0100, 1'b1);
      ap(6'h23, 15'h0000, 16'h00ff, 1'b0);
      ap(6'h26, 15'h00c0, 16'h0000, 1'b1);
      ap(6'h26, 15'h0080, 16'h0000, 1'b0);
      ap(6'h27, 15'h0000, 16'h0100, 1'b1);
      ap(6'h28, 15'h0000, 16'h0100, 1'b0);
      ap(6'h28, 15'h0000, 16'h0101, 1'b1);
      @(posedge clk) thr <= 16'h0200;
      ap(6'h18, 15'h0000, 16'h0101, 1'b0);
      ap(6'h23, 15'h0000, 16'h0200, 1'b1);
      ap(6'h28, 15'h0000, 16'h0201, 1'b1);
      ap(6'h00, 15'h7fff, 16'hffff, 1'b0);
      ap(6'h15, 15'h7fff, 16'hffff, 1'b0);
      ap(6'h16, 15'h7fff, 16'hffff, 1'b0);
      ap(6'h29, 15'h7fff, 16'hffff, 1'b0);
      // Clock enable low must hold the terminal although its condition is true.
      @(posedge clk) en <= 1'b0;
      ap(6'h13, 15'h0020, 16'h0000, 1'b0);
      @(posedge clk) en <= 1'b1;
      ap(6'h13, 15'h0020, 16'h0000, 1'b1);
      @(posedge clk) pol <= 5'h1f;
      ap(6'h00, 15'h0000, 16'h0000, 1'b0);
      ap(6'h13, 15'h0020, 16'h0000, 1'b1);
      @(posedge clk) pmax <= 14'h3fff;
      preq <= 14'h3fff;
      ap(6'h00, 15'h0000, 16'h0000, 1'b0);
      chk({2'h0, peff}, 16'h2710);
      chk({2'h0, pout}, 16'h2710);
      @(posedge clk) pmax <= 14'h0100;
      preq <= 14'h0200;
      ap(6'h00, 15'h0000, 16'h0000, 1'b0);
      chk({2'h0, peff}, 16'h0100);
      chk({2'h0, pout}, 16'h0100);
      @(posedge clk) pmax <= 14'h0000;
      preq <= 14'h0000;
      ap(6'h00, 15'h0000, 16'h0000, 1'b0);
      chk({2'h0, peff}, 16'h0001);
      chk({2'h0, pout}, 16'h0001);
      finish_test;
   end
endmodule // tb
